// >>> verilog/dtsd_consts.vh
// Constants of the DMA tag stream decoder
// How it works
// - Hold word: tag low 9, count high 16
// - Hold mode sends every word to same tag
// - Zero count means exactly one data word
// - Increment mode advances internal tag copy
// - Increment: mode 1, first tag, count minus one
// - Tag is 9 bits: group 5, offset 4
// - Mode 2 is indexed with 16-bit mask
// - Indexed takes group from bits 4..8
// - Set mask bits equal following data words
// - Indexed words go lowest set bit first
// - Mask 0x0032 writes offsets 1, 4, 5
// - Remaining count drops per buffer word, description or data
// - Done flag when count goes to zero
// - Interrupt only while enable bit set
// - Done flag cleared by writing one
// - Count write starts the transfer
// - Base address latched at transfer start
// - Fetching stalls while the FIFO is full
`ifndef DTSD_CONSTS_VH
`define DTSD_CONSTS_VH
`define DTSD_TAG_MSB 8
`define DTSD_GRP_LSB 4
`define DTSD_MODE_MSB 15
`define DTSD_MODE_LSB 14
`define DTSD_CNT_MSB 31
`define DTSD_CNT_LSB 16
`define DTSD_MODE_HOLD 2'h0
`define DTSD_MODE_INCR 2'h1
`define DTSD_MODE_INDEX 2'h2
`define DTSD_FIFO_WIDTH 41
`define DTSD_FIFO_DEPTH 8
`define DTSD_FIFO_AW 3
`endif

// >>> verilog/dtsd_fifo.v
// Parameterised flip-flop FIFO for tag/data pairs
`timescale 1ns/10ps
`default_nettype none
module dtsd_fifo #(
    parameter WIDTH = 41,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire reset,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wrPtr_ff;
    reg [AW-1:0] rdPtr_ff;
    reg [AW:0] level_ff;
    wire doWrite;
    wire doRead;
    assign inReady = (level_ff != DEPTH[AW:0]);
    assign outValid = (level_ff != {(AW+1){1'b0}});
    assign outData = mem_ff[rdPtr_ff];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    always @(posedge clk)
    begin
        if (reset)
        begin
            wrPtr_ff <= {AW{1'b0}};
            rdPtr_ff <= {AW{1'b0}};
            level_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            if (doWrite)
            begin
                mem_ff[wrPtr_ff] <= inData;
                wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wrPtr_ff + 1'b1;
            end
            if (doRead)
                rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rdPtr_ff + 1'b1;
            if (doWrite && !doRead)
                level_ff <= level_ff + 1'b1;
            else if (doRead && !doWrite)
                level_ff <= level_ff - 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/dtsd_decoder.v
// DMA engine that fetches a buffer and decodes tag descriptions
`timescale 1ns/10ps
`default_nettype none
`include "dtsd_consts.vh"
module dtsd_decoder (
    input wire clk,
    input wire reset,
    input wire [31:0] bufferBaseAddress,
    input wire [15:0] countWriteData,
    input wire countWriteStrobe,
    input wire transferDoneIrqEnable,
    input wire transferDoneFlagClear,
    output reg [15:0] remainingWordCount_ff,
    output reg transferDoneFlag_ff,
    output reg irqOut_ff,
    output reg readReq_ff,
    output reg [31:0] readAddr_ff,
    input wire readAck,
    input wire [31:0] readData,
    output reg pairValid_ff,
    output reg [8:0] pairTag_ff,
    output reg [31:0] pairData_ff,
    input wire pairReady
);
    localparam ST_IDLE = 2'h0;
    localparam ST_FETCH = 2'h1;
    localparam ST_PUSH = 2'h2;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg isData_ff;
    reg [1:0] mode_ff;
    reg [8:0] tag_ff;
    reg [15:0] owed_ff;
    reg [15:0] mask_ff;
    reg [31:0] word_ff;
    wire fifoInReady;
    wire fifoOutValid;
    wire [`DTSD_FIFO_WIDTH-1:0] fifoOutData;
    wire pushNow;
    wire popNow;

    // Lowest set bit of a mask as a 4-bit offset
    function [3:0] lowBit;
        input [15:0] m;
        integer i;
        begin
            lowBit = 4'h0;
            for (i = 15; i >= 0; i = i - 1)
                if (m[i])
                    lowBit = i[3:0];
        end
    endfunction

    // Number of set bits in a mask
    function [15:0] popCount;
        input [15:0] m;
        integer i;
        begin
            popCount = 16'h0000;
            for (i = 0; i < 16; i = i + 1)
                popCount = popCount + {15'h0000, m[i]};
        end
    endfunction

    //------------------------------------------------------------
    // Fetch state machine
    //------------------------------------------------------------
    assign pushNow = (state_ff == ST_PUSH) && fifoInReady;
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (countWriteStrobe && countWriteData != 16'h0000)
                    nxt_state = ST_FETCH;
            ST_FETCH:
                if (readAck)
                    nxt_state = ST_PUSH;
            // A data word's count already dropped at its ack, a description's drops here
            ST_PUSH:
                if (!isData_ff)
                    nxt_state = (remainingWordCount_ff == 16'h0001) ? ST_IDLE : ST_FETCH;
                else if (fifoInReady)
                    nxt_state = (remainingWordCount_ff == 16'h0000) ? ST_IDLE : ST_FETCH;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            state_ff <= ST_IDLE;
            isData_ff <= 1'b0;
            mode_ff <= `DTSD_MODE_HOLD;
            tag_ff <= 9'h000;
            owed_ff <= 16'h0000;
            mask_ff <= 16'h0000;
            word_ff <= 32'h00000000;
            remainingWordCount_ff <= 16'h0000;
            readReq_ff <= 1'b0;
            readAddr_ff <= 32'h00000000;
            transferDoneFlag_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            readReq_ff <= (nxt_state == ST_FETCH) && !(state_ff == ST_FETCH && !readAck);
            if (state_ff == ST_FETCH && !readAck)
                readReq_ff <= 1'b1;
            if (state_ff == ST_IDLE && countWriteStrobe && countWriteData != 16'h0000)
            begin
                readAddr_ff <= bufferBaseAddress;
                remainingWordCount_ff <= countWriteData;
                isData_ff <= 1'b0;
                owed_ff <= 16'h0000;
            end
            if (state_ff == ST_FETCH && readAck)
            begin
                word_ff <= readData;
                readAddr_ff <= readAddr_ff + 32'h00000004;
                if (isData_ff)
                    remainingWordCount_ff <= remainingWordCount_ff - 16'h0001;
            end
            if (state_ff == ST_PUSH && !isData_ff)
            begin
                // Description word: decode mode, tag, count or mask
                remainingWordCount_ff <= remainingWordCount_ff - 16'h0001;
                mode_ff <= word_ff[`DTSD_MODE_MSB:`DTSD_MODE_LSB];
                tag_ff <= word_ff[`DTSD_TAG_MSB:0];
                mask_ff <= word_ff[`DTSD_CNT_MSB:`DTSD_CNT_LSB];
                if (word_ff[`DTSD_MODE_MSB:`DTSD_MODE_LSB] == `DTSD_MODE_INDEX)
                begin
                    owed_ff <= popCount(word_ff[`DTSD_CNT_MSB:`DTSD_CNT_LSB]);
                    tag_ff <= {word_ff[`DTSD_TAG_MSB:`DTSD_GRP_LSB], 4'h0};
                    isData_ff <= (word_ff[`DTSD_CNT_MSB:`DTSD_CNT_LSB] != 16'h0000);
                end
                else
                begin
                    owed_ff <= word_ff[`DTSD_CNT_MSB:`DTSD_CNT_LSB] + 16'h0001;
                    isData_ff <= 1'b1;
                end
            end
            if (pushNow && isData_ff)
            begin
                owed_ff <= owed_ff - 16'h0001;
                if (owed_ff == 16'h0001)
                    isData_ff <= 1'b0;
                if (mode_ff == `DTSD_MODE_INCR)
                    tag_ff <= tag_ff + 9'h001;
                if (mode_ff == `DTSD_MODE_INDEX)
                    mask_ff <= mask_ff & ~(16'h0001 << lowBit(mask_ff));
            end
            // Set wins over clear
            if (state_ff == ST_FETCH && readAck && isData_ff &&
                remainingWordCount_ff == 16'h0001)
                transferDoneFlag_ff <= 1'b1;
            else if (state_ff == ST_PUSH && !isData_ff && remainingWordCount_ff == 16'h0001)
                transferDoneFlag_ff <= 1'b1;
            else if (transferDoneFlagClear)
                transferDoneFlag_ff <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Pair builder and output FIFO
    //------------------------------------------------------------
    dtsd_fifo #(
        .WIDTH(`DTSD_FIFO_WIDTH),
        .DEPTH(`DTSD_FIFO_DEPTH),
        .AW(`DTSD_FIFO_AW)
    ) pairFifo (
        .clk(clk),
        .reset(reset),
        .inValid(state_ff == ST_PUSH && isData_ff),
        .inReady(fifoInReady),
        .inData((mode_ff == `DTSD_MODE_INDEX) ? {tag_ff[8:4], lowBit(mask_ff), word_ff}
            : {tag_ff, word_ff}),
        .outValid(fifoOutValid),
        .outReady(popNow),
        .outData(fifoOutData)
    );

    assign popNow = fifoOutValid && (!pairValid_ff || pairReady);

    always @(posedge clk)
    begin
        if (reset)
        begin
            pairValid_ff <= 1'b0;
            pairTag_ff <= 9'h000;
            pairData_ff <= 32'h00000000;
            irqOut_ff <= 1'b0;
        end
        else
        begin
            if (popNow)
            begin
                pairValid_ff <= 1'b1;
                pairTag_ff <= fifoOutData[40:32];
                pairData_ff <= fifoOutData[31:0];
            end
            else if (pairReady)
                pairValid_ff <= 1'b0;
            irqOut_ff <= transferDoneFlag_ff && transferDoneIrqEnable;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/dtsd_decoder_checker.sv
// Port assertions for the tag stream decoder
`timescale 1ns/10ps
`default_nettype none
module dtsd_decoder_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] bufferBaseAddress,
    input wire logic [15:0] countWriteData,
    input wire logic countWriteStrobe,
    input wire logic transferDoneIrqEnable,
    input wire logic transferDoneFlagClear,
    input wire logic [15:0] remainingWordCount_ff,
    input wire logic transferDoneFlag_ff,
    input wire logic irqOut_ff,
    input wire logic readReq_ff,
    input wire logic [31:0] readAddr_ff,
    input wire logic readAck,
    input wire logic pairValid_ff,
    input wire logic [31:0] pairData_ff,
    input wire logic pairReady
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [31:0] ackAddr_ff = 32'h0;
    always @(posedge clk)
        if (readReq_ff && readAck)
            ackAddr_ff <= readAddr_ff;
    AST_START: assert property (countWriteStrobe && countWriteData != 16'h0 &&
        !readReq_ff && remainingWordCount_ff == 16'h0 |=> readReq_ff) else $error("no fetch");
    AST_BASE: assert property ($rose(readReq_ff) && $past(countWriteStrobe) |->
        readAddr_ff == $past(bufferBaseAddress)) else $error("bad base");
    AST_STEP: assert property ($rose(readReq_ff) && !$past(countWriteStrobe) |->
        readAddr_ff == ackAddr_ff + 32'h4) else $error("bad step");
    AST_REQ: assert property (readReq_ff && !readAck |=>
        readReq_ff && $stable(readAddr_ff)) else $error("request dropped");
    AST_PAIR: assert property (pairValid_ff && !pairReady |=>
        pairValid_ff && $stable(pairData_ff)) else $error("pair dropped");
    AST_COUNT: assert property (remainingWordCount_ff != $past(remainingWordCount_ff) &&
        !$past(countWriteStrobe) |-> remainingWordCount_ff == $past(remainingWordCount_ff) - 16'h1)
        else $error("bad count step");
    AST_DONE: assert property ($past(remainingWordCount_ff) != 16'h0 &&
        remainingWordCount_ff == 16'h0 |-> ##[0:1] transferDoneFlag_ff) else $error("no done");
    AST_IRQ: assert property (irqOut_ff == $past(transferDoneFlag_ff && transferDoneIrqEnable))
        else $error("bad irq");
    AST_CLEAR: assert property (transferDoneFlagClear && remainingWordCount_ff == 16'h0 &&
        !countWriteStrobe |=> !transferDoneFlag_ff) else $error("flag not cleared");
    AST_STICKY: assert property (transferDoneFlag_ff && !transferDoneFlagClear |=>
        transferDoneFlag_ff) else $error("flag lost");
    cover property (irqOut_ff);
    cover property (pairValid_ff && !pairReady);
    cover property (readReq_ff && readAck && remainingWordCount_ff == 16'h1);
endmodule
`default_nettype wire

// >>> testbench/dtsd_mem_model.sv
// Host memory answering the decoder's word reads
`timescale 1ns/10ps
`default_nettype none
module dtsd_mem_model (
    input wire logic clk,
    input wire logic readReq,
    input wire logic [31:0] readAddr,
    input wire logic slow,
    output var logic readAck = 1'b0,
    output var logic [31:0] readData = 32'h0
);
    logic [31:0] mem [0:63];
    logic [1:0] waitCnt_ff = 2'h0;
    // Data toggles when no word is offered
    always @(posedge clk)
    begin
        readAck <= 1'b0;
        readData <= ~readData;
        if (readReq && !readAck)
        begin
            waitCnt_ff <= waitCnt_ff + 2'h1;
            if (!slow || waitCnt_ff == 2'h3)
            begin
                readAck <= 1'b1;
                readData <= mem[readAddr[7:2]];
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the tag stream decoder
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] bufferBaseAddress = 32'h0;
    logic [15:0] countWriteData = 16'h0;
    logic countWriteStrobe = 1'b0;
    logic transferDoneIrqEnable = 1'b0;
    logic transferDoneFlagClear = 1'b0;
    logic pairReady = 1'b0;
    logic stall = 1'b0;
    logic slow = 1'b0;
    wire [15:0] remainingWordCount_ff;
    wire transferDoneFlag_ff, irqOut_ff, readReq_ff, readAck, pairValid_ff;
    wire [31:0] readAddr_ff, readData, pairData_ff;
    wire [8:0] pairTag_ff;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [40:0] expq[$];
    logic [31:0] w[$];
    always #20 clk = ~clk;
    dtsd_decoder u_dut (.clk, .reset, .bufferBaseAddress, .countWriteData, .countWriteStrobe,
        .transferDoneIrqEnable, .transferDoneFlagClear, .remainingWordCount_ff,
        .transferDoneFlag_ff, .irqOut_ff, .readReq_ff, .readAddr_ff, .readAck, .readData,
        .pairValid_ff, .pairTag_ff, .pairData_ff, .pairReady);
    dtsd_mem_model u_mem (.clk, .readReq(readReq_ff), .readAddr(readAddr_ff), .slow, .readAck,
        .readData);
    function automatic logic [31:0] desc(input logic [15:0] c, input logic [1:0] md,
        input logic [8:0] t);
        return {c, md, 5'h0, t};
    endfunction
    task automatic check(input logic [40:0] seen, input logic [40:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Loads the buffer, predicts its pairs, runs one transfer
    task automatic run(input int id, input logic [31:0] b);
        int i;
        int d;
        logic [1:0] md;
        logic [15:0] m;
        i = 0;
        foreach (w[k])
            u_mem.mem[b[7:2] + k] = w[k];
        while (i < w.size())
        begin
            d = i;
            md = w[d][15:14];
            m = w[d][31:16];
            for (int j = 0; j <= (md == 2'h2 ? 15 : int'(m)); j++)
            begin
                if (md != 2'h2 || m[j])
                begin
                    expq.push_back({md == 2'h2 ? {w[d][8:4], 4'(j)} :
                        9'(w[d][8:0] + (md == 2'h1 ? j : 0)), w[i + 1]});
                    i++;
                end
            end
            i++;
        end
        @(negedge clk);
        bufferBaseAddress = b;
        countWriteData = 16'(w.size());
        countWriteStrobe = 1'b1;
        @(negedge clk);
        countWriteStrobe = 1'b0;
        bufferBaseAddress = $urandom;
        for (i = 0; i < 3000 && (remainingWordCount_ff !== 16'h0 || expq.size() != 0); i++)
            @(negedge clk);
        check(41'(remainingWordCount_ff), 41'h0);
        check(41'(transferDoneFlag_ff), 41'h1);
        check(41'(irqOut_ff), 41'(transferDoneIrqEnable));
        transferDoneFlagClear = 1'b1;
        @(negedge clk);
        transferDoneFlagClear = 1'b0;
        @(negedge clk);
        check(41'(transferDoneFlag_ff), 41'h0);
        $display("test %0d done", id);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (pairValid_ff === 1'b1 && pairReady)
            check({pairTag_ff, pairData_ff}, expq.pop_front());
        if (cycles == 30000)
        begin
            bad_count++;
            close_out();
        end
    end
    always @(negedge clk)
        pairReady <= !stall && ($urandom_range(3) != 0);
    initial
    begin
        logic [1:0] md;
        logic [15:0] r;
        void'($urandom(29619));
        repeat (5) @(negedge clk);
        reset = 1'b0;
        w = '{desc(16'h2, 2'h0, 9'h1A5), $urandom, $urandom, $urandom,
            desc(16'h0, 2'h0, 9'h0F3), $urandom};
        run(1, 32'h0);
        transferDoneIrqEnable = 1'b1;
        slow = 1'b1;
        w = '{desc(16'h7, 2'h1, 9'h1F8)};
        repeat (8) w.push_back($urandom);
        run(2, 32'h40);
        w = '{32'h003280F0, $urandom, $urandom, $urandom, desc(16'h0, 2'h2, 9'h1FF),
            desc(16'h8001, 2'h2, 9'h02C), $urandom, $urandom};
        run(3, 32'h0);
        transferDoneIrqEnable = 1'b0;
        slow = 1'b0;
        w = '{desc(16'h13, 2'h0, 9'h0AA)};
        repeat (20) w.push_back($urandom);
        fork
            begin
                stall = 1'b1;
                repeat (60) @(negedge clk);
                stall = 1'b0;
            end
        join_none
        run(4, 32'h80);
        for (int n = 5; n < 9; n++)
        begin
            md = 2'($urandom_range(2));
            r = md == 2'h2 ? 16'($urandom) : 16'($urandom_range(7));
            w = '{desc(r, md, 9'($urandom))};
            repeat (md == 2'h2 ? $countones(r) : r + 1) w.push_back($urandom);
            run(n, 32'h0);
        end
        close_out();
    end
endmodule
bind dtsd_decoder dtsd_decoder_checker u_chk (.clk, .reset, .bufferBaseAddress, .countWriteData,
    .countWriteStrobe, .transferDoneIrqEnable, .transferDoneFlagClear, .remainingWordCount_ff,
    .transferDoneFlag_ff, .irqOut_ff, .readReq_ff, .readAddr_ff, .readAck, .pairValid_ff,
    .pairData_ff, .pairReady);
`default_nettype wire
